// ===== gpe_game_irq.sv
`timescale 1ns/10ps
`include "gpe_defines.svh"

// Operation
// - writing one clears status bit, zero keeps
// - reading a position counter high byte clears its ready
// - status and enable act only in enhanced
// - status bits: buttons 7-4, ready 3-0
// - selected button edge sets sticky event flag
// - completed axis count sets its ready flag
// - enable bits 7-4 gate button interrupts
// - enable bit 2 picks both or either
// - enable bit 1 gates device B position
// - enable bit 0 gates device A position
// - control bit 0 enables enhanced, resets zero
// - legacy status write pulses axes, restarts counters only in enhanced
// - two-bit polarity: none, rise, fall, both
// - optional debounce filter before edge detection
module gpe_game_irq #(
  parameter int DEBOUNCE_CYC = `GPE_DEBOUNCE_CYC,
  parameter int PULSE_CYC = `GPE_PULSE_CYC,
  parameter int TICK_CYC = `GPE_TICK_CYC,
  parameter int POS_W = `GPE_POS_W
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [5:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // buttons: 0 A0, 1 A1, 2 B0, 3 B1
  input wire logic [3:0] button_in,
  // axes open drain: 0 AX, 1 AY, 2 BX, 3 BY
  input wire logic [3:0] axis_in,
  output logic [3:0] axis_out,
  output logic [3:0] axis_oe,
  // interrupt
  output logic irq
);

  localparam int PW = $clog2(PULSE_CYC + 1);
  localparam int TW = $clog2(TICK_CYC + 1);

  // ====================================================
  // decoding helpers

  function automatic logic edge_hit(
    input logic [1:0] sel,
    input logic prev,
    input logic now
  );
    logic rise;
    logic fall;
    rise = ~prev & now;
    fall = prev & ~now;
    case (sel)
      gpe_pkg::GPE_EDGE_RISE: edge_hit = rise;
      gpe_pkg::GPE_EDGE_FALL: edge_hit = fall;
      gpe_pkg::GPE_EDGE_BOTH: edge_hit = rise | fall;
      default: edge_hit = 1'b0;
    endcase
  endfunction

  function automatic logic pos_done(
    input logic either,
    input logic [1:0] rdy
  );
    pos_done = either ? (rdy[0] | rdy[1]) : (rdy[0] & rdy[1]);
  endfunction

  function automatic logic at_idx(
    input logic [3:0] a,
    input logic [3:0] r
  );
    at_idx = (a == r);
  endfunction

  // ====================================================
  // registers and state

  logic [7:0] game_port_control;
  logic [7:0] game_event_status;
  logic [7:0] game_irq_enable;
  logic [7:0] button_edge_select;
  logic [POS_W-1:0] pos_cnt [4];
  logic [3:0] ax_done;
  logic [3:0] btn_clean;
  logic [3:0] btn_prev;
  logic [3:0] btn_event;
  logic [3:0] rdy_event;
  logic [3:0] rdy_read_clr;
  logic [7:0] w1c_clr;
  logic [7:0] next_dat;
  logic [PW-1:0] pulse_cnt;
  logic [TW-1:0] tick_cnt;
  logic base_tick;
  logic half_phase;
  logic [3:0] axis_tick;
  gpe_pkg::gpe_axis_state_t ax_state;

  logic enh;
  logic req;
  logic [3:0] idx;
  logic [3:0] pos_off;
  logic is_pos;
  logic wr_ok;
  logic rd_ok;
  logic start;

  assign enh = game_port_control[`GPE_CTL_ENH];

  // ====================================================
  // wishbone access

  assign req = wb_cyc_i & wb_stb_i;
  assign idx = wb_adr_i[5:2];
  assign pos_off = idx - `GPE_IDX_POS_FIRST;
  assign is_pos = (idx >= `GPE_IDX_POS_FIRST) && (idx <= `GPE_IDX_POS_LAST);
  // side effects happen only at the edge that completes the cycle
  assign wr_ok = req & wb_ack_o & wb_we_i & wb_sel_i[0];
  assign rd_ok = req & wb_ack_o & ~wb_we_i;
  assign start = wr_ok & at_idx(idx, `GPE_IDX_LEG);

  // one wait state: ack rises one edge after the request, drops after
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      wb_ack_o <= 1'b0;
    end else begin
      wb_ack_o <= req & ~wb_ack_o;
    end
  end

  always_comb begin
    next_dat = 8'h00;
    if (at_idx(idx, `GPE_IDX_CTL)) begin
      next_dat = game_port_control;
    end else if (at_idx(idx, `GPE_IDX_LEG)) begin
      // axis bits read one while the pin is still low
      next_dat = {button_in, ~axis_in};
    end else if (at_idx(idx, `GPE_IDX_ST)) begin
      next_dat = game_event_status;
    end else if (at_idx(idx, `GPE_IDX_IEN)) begin
      next_dat = game_irq_enable;
    end else if (is_pos) begin
      if (pos_off[0]) begin
        next_dat = pos_cnt[pos_off[2:1]][15:8];
      end else begin
        next_dat = pos_cnt[pos_off[2:1]][7:0];
      end
    end else if (at_idx(idx, `GPE_IDX_POL)) begin
      next_dat = button_edge_select;
    end else begin
      next_dat = 8'h00;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      wb_dat_o <= 32'h0000_0000;
    end else if (req & ~wb_ack_o) begin
      wb_dat_o <= {24'h00_0000, next_dat};
    end
  end

  // ====================================================
  // software-written configuration

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      game_port_control <= `GPE_CTL_RST;
    end else if (wr_ok & at_idx(idx, `GPE_IDX_CTL)) begin
      game_port_control <= wb_dat_i[7:0] & `GPE_CTL_WMASK;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      game_irq_enable <= `GPE_IEN_RST;
    end else if (wr_ok & at_idx(idx, `GPE_IDX_IEN)) begin
      game_irq_enable <= wb_dat_i[7:0] & `GPE_IEN_WMASK;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      button_edge_select <= `GPE_POL_RST;
    end else if (wr_ok & at_idx(idx, `GPE_IDX_POL)) begin
      button_edge_select <= wb_dat_i[7:0];
    end
  end

  // ====================================================
  // buttons: debounce and edge detection

  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++) begin : g_btn
      gpe_debounce #(
        .COUNT(DEBOUNCE_CYC)
      ) u_dbn (
        .clk(clk),
        .rst(rst),
        .enable(game_port_control[`GPE_CTL_DBN_LSB + gi]),
        .raw(button_in[gi]),
        .clean(btn_clean[gi])
      );
      assign btn_event[gi] = edge_hit(button_edge_select[2*gi+1:2*gi],
                                      btn_prev[gi], btn_clean[gi]);
    end
  endgenerate

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      btn_prev <= 4'h0;
    end else begin
      btn_prev <= btn_clean;
    end
  end

  // ====================================================
  // position counter time base

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      tick_cnt <= '0;
      half_phase <= 1'b0;
    end else if (base_tick) begin
      tick_cnt <= '0;
      half_phase <= ~half_phase;
    end else begin
      tick_cnt <= tick_cnt + 1'b1;
    end
  end

  assign base_tick = (tick_cnt == TW'(TICK_CYC - 1));
  assign axis_tick[1:0] = {2{base_tick & (~game_port_control[`GPE_CTL_PSA] | half_phase)}};
  assign axis_tick[3:2] = {2{base_tick & (~game_port_control[`GPE_CTL_PSB] | half_phase)}};

  // ====================================================
  // axis measurement sequencer

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ax_state <= gpe_pkg::GPE_AX_IDLE;
      pulse_cnt <= '0;
    end else if (start) begin
      // a new write restarts the measurement from any state
      ax_state <= gpe_pkg::GPE_AX_PULSE;
      pulse_cnt <= '0;
    end else begin
      case (ax_state)
        gpe_pkg::GPE_AX_PULSE: begin
          pulse_cnt <= pulse_cnt + 1'b1;
          if (pulse_cnt == PW'(PULSE_CYC - 1)) begin
            ax_state <= gpe_pkg::GPE_AX_MEAS;
          end
        end
        gpe_pkg::GPE_AX_MEAS: begin
          if (&ax_done) begin
            ax_state <= gpe_pkg::GPE_AX_IDLE;
          end
        end
        default: begin
          ax_state <= gpe_pkg::GPE_AX_IDLE;
        end
      endcase
    end
  end

  // pins are only ever pulled low; released they charge through the pot
  assign axis_out = 4'h0;
  assign axis_oe = {4{ax_state == gpe_pkg::GPE_AX_PULSE}};

  generate
    for (gi = 0; gi < 4; gi++) begin : g_axis
      // a counter stuck at full scale counts as finished, so in enhanced mode
      // a missing device cannot hold the sequencer forever
      assign rdy_event[gi] = (ax_state == gpe_pkg::GPE_AX_MEAS) & ~ax_done[gi]
                             & (axis_in[gi] | (&pos_cnt[gi]));

      always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
          ax_done[gi] <= 1'b0;
        end else if (start) begin
          ax_done[gi] <= 1'b0;
        end else if (rdy_event[gi]) begin
          ax_done[gi] <= 1'b1;
        end
      end

      always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
          pos_cnt[gi] <= '0;
        end else if (start & enh) begin
          pos_cnt[gi] <= '0;
        end else if (enh & axis_tick[gi] & ~ax_done[gi] & ~rdy_event[gi]
                     & (ax_state == gpe_pkg::GPE_AX_MEAS)) begin
          pos_cnt[gi] <= pos_cnt[gi] + 1'b1;
        end
      end

      // the high byte is read last, so it releases the ready flag
      assign rdy_read_clr[gi] = rd_ok & is_pos & pos_off[0]
                                & (pos_off[2:1] == 2'(gi));
    end
  endgenerate

  // ====================================================
  // event status, write one to clear

  assign w1c_clr = (wr_ok & at_idx(idx, `GPE_IDX_ST)) ? wb_dat_i[7:0] : 8'h00;

  // a set in the same cycle as its clear wins, so no event is lost
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      game_event_status <= `GPE_ST_RST;
    end else begin
      game_event_status[7:4] <= (game_event_status[7:4] & ~w1c_clr[7:4])
                                | ({4{enh}} & btn_event);
      game_event_status[3:0] <= (game_event_status[3:0] & ~w1c_clr[3:0]
                                 & ~rdy_read_clr)
                                | ({4{enh}} & rdy_event);
    end
  end

  // ====================================================
  // interrupt request

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      irq <= 1'b0;
    end else begin
      irq <= enh & (
        (|(game_event_status[7:4] & game_irq_enable[7:4]))
        | (game_irq_enable[`GPE_IEN_POS_A]
           & pos_done(game_irq_enable[`GPE_IEN_POS_DEF], game_event_status[1:0]))
        | (game_irq_enable[`GPE_IEN_POS_B]
           & pos_done(game_irq_enable[`GPE_IEN_POS_DEF], game_event_status[3:2])));
    end
  end

endmodule

// ===== gpe_defines.svh
`ifndef GPE_DEFINES_SVH
`define GPE_DEFINES_SVH

// ====================================================
// register indices (byte address is four times the index)
`define GPE_IDX_CTL 4'h0
`define GPE_IDX_LEG 4'h1
`define GPE_IDX_ST 4'h2
`define GPE_IDX_IEN 4'h3
`define GPE_IDX_POS_FIRST 4'h4
`define GPE_IDX_POS_LAST 4'hb
`define GPE_IDX_POL 4'hc

// ====================================================
// field positions
`define GPE_CTL_ENH 0
`define GPE_CTL_PSA 1
`define GPE_CTL_PSB 2
`define GPE_CTL_DBN_LSB 4
`define GPE_IEN_POS_A 0
`define GPE_IEN_POS_B 1
`define GPE_IEN_POS_DEF 2
`define GPE_IEN_BTN_LSB 4
`define GPE_ST_BTN_LSB 4
`define GPE_ST_RDY_LSB 0

// ====================================================
// reset values and writable bits
`define GPE_CTL_RST 8'h00
`define GPE_ST_RST 8'h00
`define GPE_IEN_RST 8'h00
`define GPE_POL_RST 8'h00
`define GPE_CTL_WMASK 8'hf7
`define GPE_IEN_WMASK 8'hf7

// ====================================================
// timing
`define GPE_CLK_PERIOD_NS 10
`define GPE_PULSE_NS 10000
`define GPE_PULSE_CYC ((`GPE_PULSE_NS + `GPE_CLK_PERIOD_NS - 1) / `GPE_CLK_PERIOD_NS)
`define GPE_TICK_NS 1000
`define GPE_TICK_CYC (`GPE_TICK_NS / `GPE_CLK_PERIOD_NS)
`define GPE_DEBOUNCE_MS 16
`define GPE_DEBOUNCE_CYC (`GPE_DEBOUNCE_MS * 1000000 / `GPE_CLK_PERIOD_NS)
`define GPE_POS_W 16

`endif

// ===== gpe_pkg.sv
package gpe_pkg;

  // ====================================================
  // axis measurement sequencer
  typedef enum logic [2:0] {
    GPE_AX_IDLE = 3'b001,
    GPE_AX_PULSE = 3'b010,
    GPE_AX_MEAS = 3'b100
  } gpe_axis_state_t;

  // ====================================================
  // button event polarity codes
  typedef enum logic [1:0] {
    GPE_EDGE_NONE = 2'b00,
    GPE_EDGE_RISE = 2'b01,
    GPE_EDGE_FALL = 2'b10,
    GPE_EDGE_BOTH = 2'b11
  } gpe_edge_t;

endpackage

// ===== gpe_debounce.sv
`timescale 1ns/10ps

module gpe_debounce #(
  parameter int COUNT = 1600000
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // filter
  input wire logic enable,
  input wire logic raw,
  output logic clean
);

  localparam int CW = $clog2(COUNT + 1);

  logic [CW-1:0] cnt;

  // the output follows only a level that held for the whole window
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cnt <= '0;
      clean <= 1'b0;
    end else if (!enable || raw == clean) begin
      cnt <= '0;
      if (!enable) begin
        clean <= raw;
      end
    end else if (cnt == CW'(COUNT - 1)) begin
      cnt <= '0;
      clean <= raw;
    end else begin
      cnt <= cnt + 1'b1;
    end
  end

endmodule

// ===== gpe_joy_model.sv
`timescale 1ns/10ps

// ====================================================
// two game devices: rc axis pins with pull-up, charging after release
module gpe_joy_model #(
  parameter logic [3:0][7:0] DLY = {8'h28, 8'h14, 8'h1e, 8'h0a}
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // axis pins
  input wire logic [3:0] axis_out,
  input wire logic [3:0] axis_oe,
  output logic [3:0] axis_in
);
  logic [3:0][7:0] chg;

  // counters saturate so an idle pin reads charged
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      chg <= {4{8'hff}};
    end else begin
      for (int i = 0; i < 4; i++) begin
        if (axis_oe[i]) begin
          chg[i] <= 8'h00;
        end else if (chg[i] != 8'hff) begin
          chg[i] <= chg[i] + 8'h01;
        end
      end
    end
  end

  // pin low while pulled down or still charging
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      axis_in[i] = !(axis_oe[i] && !axis_out[i]) && (chg[i] >= DLY[i]);
    end
  end
endmodule

// ===== gpe_sva.sv
`timescale 1ns/10ps
`include "gpe_defines.svh"

// ====================================================
// bus and pin checks of the game port block
module gpe_sva #(
  parameter int PULSE_CYC = `GPE_PULSE_CYC
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // bus
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [5:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  // pins
  input wire logic [3:0] button_in,
  input wire logic [3:0] axis_in,
  input wire logic [3:0] axis_out,
  input wire logic [3:0] axis_oe,
  input wire logic irq
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  int oe_len;
  wire rd_ack = wb_ack_o && !wb_we_i;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) oe_len <= 0;
    else if (axis_oe[0]) oe_len <= oe_len + 1;
    else oe_len <= 0;
  end

  ack_follow_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("request not answered next cycle");
  ack_single_a: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  idle_no_ack_a: assert property (!wb_cyc_i |=> !wb_ack_o)
    else $error("ack without request");
  upper_zero_a: assert property (wb_ack_o |-> wb_dat_o[31:8] == 24'h0)
    else $error("read data upper bits not zero");
  unmapped_zero_a: assert property (rd_ack && wb_adr_i[5:2] > 4'hc |-> wb_dat_o == 32'h0)
    else $error("unmapped read not zero");
  resv_bit_a: assert property (
    rd_ack && (wb_adr_i[5:2] == 4'h0 || wb_adr_i[5:2] == 4'h3) |-> !wb_dat_o[3])
    else $error("reserved bit reads one");
  drain_only_a: assert property (axis_out == 4'h0)
    else $error("axis pin driven high");
  oe_group_a: assert property (axis_oe == 4'h0 || axis_oe == 4'hf)
    else $error("axis pins not pulsed together");
  start_pulse_a: assert property (
    wb_ack_o && wb_we_i && wb_sel_i[0] && wb_adr_i[5:2] == 4'h1 |-> ##[1:2] axis_oe == 4'hf)
    else $error("legacy write did not pulse axes");
  pulse_len_a: assert property ($fell(axis_oe[0]) |-> oe_len == PULSE_CYC)
    else $error("axis pulse length wrong");
  // leaving enhanced mode forces the request low one edge after the write lands
  legacy_irq_off_a: assert property (
    wb_cyc_i && wb_stb_i && wb_ack_o && wb_we_i && wb_sel_i[0] && wb_adr_i[5:2] == 4'h0
    && !wb_dat_i[0] |-> ##2 !irq)
    else $error("irq high in legacy mode");
endmodule

// ===== testbench.sv
`timescale 1ns/10ps

module testbench;
  logic clk, rst, wb_cyc, wb_stb, wb_we, wb_ack_o, irq;
  logic [5:0] wb_adr;
  logic [3:0] wb_sel, button_in, axis_in, axis_out, axis_oe;
  logic [31:0] wb_dat, wb_dat_o;
  logic [7:0] q;
  int n_errors = 0;
  int tests_run = 0;

  gpe_game_irq #(.DEBOUNCE_CYC(4), .PULSE_CYC(4), .TICK_CYC(2), .POS_W(16)) dut_u (
    .clk(clk), .rst(rst), .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb), .wb_we_i(wb_we),
    .wb_adr_i(wb_adr), .wb_sel_i(wb_sel), .wb_dat_i(wb_dat), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o), .button_in(button_in), .axis_in(axis_in), .axis_out(axis_out),
    .axis_oe(axis_oe), .irq(irq));
  gpe_joy_model joy_u (.clk(clk), .rst(rst), .axis_out(axis_out), .axis_oe(axis_oe),
    .axis_in(axis_in));

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  task automatic close_out();
    if (n_errors == 0 && tests_run > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    tests_run++;
    if (seen !== exp) begin
      n_errors++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // one classic cycle; write data only in lane 0
  task automatic wb(input logic we, input logic [3:0] idx, input logic [7:0] d,
                    input logic [3:0] sel);
    int n;
    @(posedge clk);
    wb_cyc <= 1'b1;
    wb_stb <= 1'b1;
    wb_we <= we;
    wb_adr <= {idx, 2'b00};
    wb_sel <= sel;
    wb_dat <= {24'h0, d};
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 50);
    if (n >= 50) begin
      n_errors++;
      close_out();
    end
    q = wb_dat_o[7:0];
    wb_cyc <= 1'b0;
    wb_stb <= 1'b0;
  endtask

  task automatic wr(input logic [3:0] idx, input logic [7:0] d);
    wb(1'b1, idx, d, 4'hf);
  endtask

  task automatic rd(input logic [3:0] idx);
    wb(1'b0, idx, 8'h00, 4'hf);
  endtask

  // irq is registered behind status, so let it settle
  task automatic irq_is(input logic exp);
    repeat (3) @(posedge clk);
    chk({7'h0, irq}, {7'h0, exp});
  endtask

  initial begin
    rst <= 1'b1;
    {wb_cyc, wb_stb, wb_we, wb_adr, wb_sel, wb_dat} <= '0;
    button_in <= 4'h0;
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    rd(4'h2); chk(q, 8'h00);
    rd(4'h3); chk(q, 8'h00);
    rd(4'h0); chk(q, 8'h00);
    wb(1'b1, 4'h0, 8'h01, 4'he);
    rd(4'h0); chk(q, 8'h00);
    wr(4'he, 8'hff);
    rd(4'he); chk(q, 8'h00);
    wr(4'h0, 8'h01);
    rd(4'h0); chk(q, 8'h01);
    wr(4'h3, 8'hff);
    rd(4'h3); chk(q, 8'hf7);
    wr(4'h3, 8'h00);
    // b0 rise, b1 fall, b2 both, b3 none
    wr(4'hc, 8'h39);
    @(posedge clk) button_in <= 4'hf;
    repeat (4) @(posedge clk);
    rd(4'h2); chk(q, 8'h50);
    rd(4'h1); chk(q, 8'hf0);
    wr(4'h2, 8'hf0);
    rd(4'h2); chk(q, 8'h00);
    @(posedge clk) button_in <= 4'h0;
    repeat (4) @(posedge clk);
    rd(4'h2); chk(q, 8'h60);
    wr(4'h3, 8'h40);
    irq_is(1'b1);
    wr(4'h2, 8'h20);
    rd(4'h2); chk(q, 8'h40);
    wr(4'h3, 8'h20);
    irq_is(1'b0);
    wr(4'h2, 8'hff);
    // position reading; A needs both, then either
    wr(4'h3, 8'h01);
    wr(4'h1, 8'h00);
    for (int i = 0; i < 100 && q !== 8'h0f; i++) rd(4'h2);
    chk(q, 8'h0f);
    irq_is(1'b1);
    rd(4'h4); chk({7'h0, q != 8'h00}, 8'h01);
    rd(4'h5); chk(q, 8'h00);
    rd(4'h2); chk(q, 8'h0e);
    irq_is(1'b0);
    wr(4'h3, 8'h05);
    irq_is(1'b1);
    rd(4'h7);
    rd(4'h2); chk(q, 8'h0c);
    irq_is(1'b0);
    wr(4'h3, 8'h04);
    irq_is(1'b0);
    wr(4'h3, 8'h02);
    irq_is(1'b1);
    rd(4'h8);
    rd(4'h2); chk(q, 8'h0c);
    rd(4'h9);
    rd(4'h2); chk(q, 8'h08);
    irq_is(1'b0);
    // debounce on button A0: a short glitch is filtered, a long press is not
    wr(4'h2, 8'hff);
    wr(4'h0, 8'h11);
    @(posedge clk) button_in <= 4'h1;
    repeat (2) @(posedge clk);
    button_in <= 4'h0;
    repeat (8) @(posedge clk);
    rd(4'h2); chk(q, 8'h00);
    button_in <= 4'h1;
    repeat (10) @(posedge clk);
    rd(4'h2); chk(q, 8'h10);
    // legacy mode: events and ready flags blocked
    wr(4'h0, 8'h00);
    wr(4'h3, 8'hff);
    irq_is(1'b0);
    wr(4'h2, 8'hff);
    @(posedge clk) button_in <= 4'hf;
    wr(4'h1, 8'h00);
    repeat (100) @(posedge clk);
    rd(4'h2); chk(q, 8'h00);
    irq_is(1'b0);
    close_out();
  end
endmodule

bind gpe_game_irq gpe_sva #(.PULSE_CYC(PULSE_CYC)) sva_u (.clk, .rst, .wb_cyc_i, .wb_stb_i,
  .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .button_in, .axis_in,
  .axis_out, .axis_oe, .irq);
